// ==== bus_condition_detect.sv ====
// edge and start/stop detection on the two-wire bus pins
`timescale 1ns/1ps
module bus_condition_detect (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda,
  output logic sclRise,
  output logic sclFall,
  output logic startSeen,
  output logic stopSeen
);
  logic prevScl; // clock line one cycle ago
  logic prevSda; // data line one cycle ago

  // idle bus is high, so history resets high
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prevScl <= 1'b1;
      prevSda <= 1'b1;
    end
    else
    begin
      prevScl <= scl;
      prevSda <= sda;
    end
  end

  // data moving while clock high marks start or stop
  assign sclRise = !prevScl && scl;
  assign sclFall = prevScl && !scl;
  assign startSeen = prevScl && scl && prevSda && !sda;
  assign stopSeen = prevScl && scl && !prevSda && sda;
endmodule : bus_condition_detect

// ==== charger_control_registers.sv ====
// charger control and identity registers behind a two-wire serial slave
// Overview of operation
// - charge control resets to 30h
// - bits 7:6 select input current limit
// - bits 5:4 select weak battery threshold
// - bit 3 enables charge termination
// - float voltage code in bits 7:2
// - float voltage register resets to 0Ah
// - identity readable at 03h and 3Bh
// - supplier code fixed, read-only
// - variant code fixed, read-only
// - revision minor digit fixed, read-only
// - charge current register resets to 89h
// - writing reset bit restores defaults, reads one
// - bits 6:4 charge current code
// - bits 2:0 termination current code
// - addressed serial slave, msb first
`timescale 1ns/1ps
`include "charger_map.svh"
module charger_control_registers #(
  parameter logic [2:0] SUPPLIER_CODE = 3'h2, // arbitrary value
  parameter logic [1:0] VARIANT_CODE = 2'h1, // arbitrary value
  parameter logic [2:0] SILICON_VERSION = 3'h0, // arbitrary value
  parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic [1:0] inputCurrentLimitSel,
  output logic [1:0] weakBatteryThreshold,
  output logic terminationEnable,
  output logic chargeDisable,
  output logic highImpedanceSelect,
  output logic boostSelect,
  output logic [5:0] floatVoltageCode,
  output logic hostPinPolarity,
  output logic hostPinEnable,
  output logic [2:0] chargeCurrentCode,
  output logic [2:0] terminationCurrentCode
);
  charger_pkg::link_state_e state; // serial engine state
  charger_pkg::byte_kind_e kind; // role of byte in flight
  logic sclRise; // clock line rose
  logic sclFall; // clock line fell
  logic startSeen; // start or repeated start
  logic stopSeen; // stop condition
  logic [2:0] bitCnt; // bit position in byte
  logic [7:0] shiftReg; // receive and transmit shifter
  logic [7:0] regPtr; // register pointer, auto-increments
  logic readMode; // last address byte asked to read
  logic addrMatch; // address byte is ours
  logic wrEn; // commit a received data byte
  logic [7:0] rdNow; // contents at the pointer
  logic [7:0] chargeControl; // stored control register
  logic [7:0] floatVoltageControl; // stored float voltage
  logic [7:0] chargeCurrentControl; // stored charge current
  logic [7:0] identity; // fixed identity byte

  // pin history and bus conditions
  bus_condition_detect u_detect (
    .core_clk(core_clk),
    .nrst(nrst),
    .scl(scl),
    .sda(sdaIn),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  // writable register storage
  charger_reg_store u_store (
    .core_clk(core_clk),
    .nrst(nrst),
    .wrEn(wrEn),
    .wrAddr(regPtr),
    .wrData(shiftReg),
    .chargeControl(chargeControl),
    .floatVoltageControl(floatVoltageControl),
    .chargeCurrentControl(chargeCurrentControl)
  );

  // identity byte is wired, writes never reach it
  assign identity = {SUPPLIER_CODE, VARIANT_CODE,
    SILICON_VERSION};

  // read decode, unmapped offsets answer zero
  function automatic logic [7:0] regRead(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `CTRL_ADDR: v = chargeControl;
      `FVOLT_ADDR: v = floatVoltageControl;
      `ID_ADDR, `ID_ALIAS_ADDR: v = identity;
      `ICUR_ADDR: v = chargeCurrentControl;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : regRead

  // read mux as a process so it follows every stored register,
  // not only pointer moves
  always_comb
  begin
    rdNow = regRead(regPtr);
  end
  assign addrMatch = shiftReg[7:1] == SLAVE_ADDR;
  // commit happens as the ack bit is about to be driven
  assign wrEn = state == charger_pkg::ACK_WAIT && sclFall
    && kind == charger_pkg::KIND_DATA;

  // field outputs straight off the storage flops
  assign inputCurrentLimitSel = chargeControl[`ILIM_HI:`ILIM_LO];
  assign weakBatteryThreshold = chargeControl[`WEAK_HI:`WEAK_LO];
  assign terminationEnable = chargeControl[`TERM_BIT];
  assign chargeDisable = chargeControl[`CDIS_BIT];
  assign highImpedanceSelect = chargeControl[`HIZ_BIT];
  assign boostSelect = chargeControl[`BOOST_BIT];
  assign floatVoltageCode = floatVoltageControl[`FV_HI:`FV_LO];
  assign hostPinPolarity = floatVoltageControl[`POL_BIT];
  assign hostPinEnable = floatVoltageControl[`HPEN_BIT];
  assign chargeCurrentCode =
    chargeCurrentControl[`ICHG_HI:`ICHG_LO];
  assign terminationCurrentCode =
    chargeCurrentControl[`TCUR_HI:`TCUR_LO];

  // serial engine sequencing; start beats everything
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= charger_pkg::IDLE;
      kind <= charger_pkg::KIND_ADDR;
    end
    else if (startSeen)
    begin
      state <= charger_pkg::RX_BYTE;
      kind <= charger_pkg::KIND_ADDR;
    end
    else if (stopSeen)
      state <= charger_pkg::IDLE;
    else
    begin
      unique case (state)
        charger_pkg::IDLE:
          state <= charger_pkg::IDLE;
        charger_pkg::RX_BYTE:
          // eighth bit sampled, ack slot next
          if (sclRise && bitCnt == `LAST_BIT)
            state <= charger_pkg::ACK_WAIT;
        charger_pkg::ACK_WAIT:
          // foreign address: stay silent until next start
          if (sclFall)
            state <= (kind == charger_pkg::KIND_ADDR && !addrMatch)
              ? charger_pkg::IDLE : charger_pkg::ACK_HOLD;
        charger_pkg::ACK_HOLD:
          if (sclFall)
          begin
            if (readMode)
              state <= charger_pkg::TX_BYTE;
            else
            begin
              state <= charger_pkg::RX_BYTE;
              // register address first, then data bytes
              kind <= (kind == charger_pkg::KIND_ADDR)
                ? charger_pkg::KIND_REG : charger_pkg::KIND_DATA;
            end
          end
        charger_pkg::TX_BYTE:
          if (sclFall && bitCnt == `LAST_BIT)
            state <= charger_pkg::MASTER_ACK;
        charger_pkg::MASTER_ACK:
          // master ack continues, nack ends our turn
          if (sclRise)
            state <= sdaIn ? charger_pkg::IDLE : charger_pkg::ACK_HOLD;
      endcase
    end
  end

  // shifter and bit counter, msb first both ways
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bitCnt <= 3'h0;
      shiftReg <= 8'h00;
    end
    else if (startSeen)
      bitCnt <= 3'h0;
    else if (state == charger_pkg::RX_BYTE && sclRise)
    begin
      shiftReg <= {shiftReg[6:0], sdaIn};
      bitCnt <= bitCnt + 3'h1;
    end
    else if (state == charger_pkg::ACK_HOLD && sclFall)
    begin
      bitCnt <= 3'h0;
      // snapshot so a changing field cannot tear the byte
      if (readMode)
        shiftReg <= rdNow;
    end
    else if (state == charger_pkg::TX_BYTE && sclFall)
    begin
      shiftReg <= {shiftReg[6:0], 1'b0};
      bitCnt <= bitCnt + 3'h1;
    end
  end

  // register pointer and direction
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      regPtr <= 8'h00;
      readMode <= 1'b0;
    end
    else if (state == charger_pkg::ACK_WAIT && sclFall)
    begin
      unique case (kind)
        charger_pkg::KIND_ADDR:
          if (addrMatch)
            readMode <= shiftReg[0];
        charger_pkg::KIND_REG:
          regPtr <= shiftReg;
        charger_pkg::KIND_DATA:
          regPtr <= regPtr + 8'h01;
      endcase
    end
    else if (state == charger_pkg::MASTER_ACK && sclRise && !sdaIn)
      regPtr <= regPtr + 8'h01;
  end

  // open-drain data drive; only ever pulls low
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      sdaOe <= 1'b0;
    else if (startSeen || stopSeen)
      sdaOe <= 1'b0;
    else if (state == charger_pkg::ACK_WAIT && sclFall)
      sdaOe <= !(kind == charger_pkg::KIND_ADDR && !addrMatch);
    else if (state == charger_pkg::ACK_HOLD && sclFall)
      sdaOe <= readMode && !rdNow[7];
    else if (state == charger_pkg::TX_BYTE && sclFall)
      sdaOe <= (bitCnt == `LAST_BIT) ? 1'b0 : !shiftReg[6];
  end

  // driven level is always low; the enable does the work
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      sdaOut <= 1'b0;
    else
      sdaOut <= 1'b0;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_ctrl_reset_value: assert property (
    $rose(nrst) |-> chargeControl == `CTRL_RST
      && floatVoltageControl == `FVOLT_RST
      && chargeCurrentControl == `ICUR_RST)
    else $error("bank did not leave reset at defaults");

  a_ctrl_write_lands: assert property (
    wrEn && regPtr == `CTRL_ADDR
      |=> inputCurrentLimitSel == $past(shiftReg[7:6])
        && boostSelect == $past(shiftReg[0]))
    else $error("charge control write not applied");

  a_fvolt_write_lands: assert property (
    wrEn && regPtr == `FVOLT_ADDR
      |=> floatVoltageCode == $past(shiftReg[7:2])
        && hostPinEnable == $past(shiftReg[0]))
    else $error("float voltage write not applied");

  a_param_reset_all: assert property (
    wrEn && regPtr == `ICUR_ADDR && shiftReg[7]
      |=> chargeControl == `CTRL_RST
        && floatVoltageControl == `FVOLT_RST
        && chargeCurrentControl == `ICUR_RST)
    else $error("parameter reset did not restore defaults");

  a_fixed_ones_read: assert property (
    (regRead(`ICUR_ADDR) & `ICUR_FIXED) == `ICUR_FIXED)
    else $error("charge current fixed bits not one");

  a_identity_alias: assert property (
    regRead(`ID_ADDR) == regRead(`ID_ALIAS_ADDR)
      && regRead(`ID_ADDR) == {SUPPLIER_CODE, VARIANT_CODE,
        SILICON_VERSION})
    else $error("identity differs between offsets");

  a_addr_ack_drive: assert property (
    state == charger_pkg::ACK_WAIT && kind == charger_pkg::KIND_ADDR
      && addrMatch && sclFall && !startSeen && !stopSeen
      |=> sdaOe ##0 state == charger_pkg::ACK_HOLD)
    else $error("own address not acknowledged");

  a_tx_msb_first: assert property (
    state == charger_pkg::ACK_HOLD && readMode && sclFall
      && !startSeen && !stopSeen
      |=> sdaOe == !$past(rdNow[7]) ##0 shiftReg == $past(rdNow))
    else $error("read byte not started at msb");

  a_stop_releases: assert property (
    stopSeen |=> !sdaOe && state == charger_pkg::IDLE ##1 !sdaOe)
    else $error("data line held after stop");

  a_data_ptr_step: assert property (
    wrEn |=> regPtr == 8'($past(regPtr) + 8'h01))
    else $error("pointer did not advance after write");

  // a foreign address must leave the line alone until the next start
  a_foreign_silent: assert property (
    state == charger_pkg::ACK_WAIT && kind == charger_pkg::KIND_ADDR
      && !addrMatch && sclFall
      |=> !sdaOe && state == charger_pkg::IDLE)
    else $error("foreign address was answered");

  // master ack moves on to the next register
  a_read_ptr_step: assert property (
    state == charger_pkg::MASTER_ACK && sclRise && !sdaIn
      |=> regPtr == 8'($past(regPtr) + 8'h01)
        && state == charger_pkg::ACK_HOLD)
    else $error("pointer did not advance after read byte");

  // ninth bit of a read belongs to the master
  a_tx_last_release: assert property (
    state == charger_pkg::TX_BYTE && sclFall && bitCnt == `LAST_BIT
      |=> !sdaOe && state == charger_pkg::MASTER_ACK)
    else $error("data line not released for master ack");

  c_ctrl_write: cover property (wrEn && regPtr == `CTRL_ADDR);
  c_param_reset: cover property (wrEn && regPtr == `ICUR_ADDR
    && shiftReg[7]);
  c_read_byte: cover property (state == charger_pkg::MASTER_ACK
    && sclRise && !sdaIn);
  c_alias_read: cover property (state == charger_pkg::TX_BYTE
    && regPtr == `ID_ALIAS_ADDR);
endmodule : charger_control_registers

// ==== charger_control_registers_test.sv ====
// self-checking bench for the charger control and identity registers
`timescale 1ns/1ps
module charger_control_registers_test;
  localparam logic [2:0] SUP = 3'h5; // arbitrary value
  localparam logic [1:0] VARI = 2'h2; // arbitrary value
  localparam logic [2:0] VERS = 3'h3; // arbitrary value
  localparam logic [7:0] ID = {SUP, VARI, VERS}; // identity byte
  logic core_clk; // 200 MHz core clock
  logic nrst; // reset, active low
  logic scl; // bus clock from the host
  logic sdaPull; // host pulls data low
  logic sdaOut; // device drive level
  logic sdaOe; // device pulls data low
  wire logic sdaLine; // open-drain wire with pull-up
  logic [1:0] inputCurrentLimitSel;
  logic [1:0] weakBatteryThreshold;
  logic terminationEnable;
  logic chargeDisable;
  logic highImpedanceSelect;
  logic boostSelect;
  logic [5:0] floatVoltageCode;
  logic hostPinPolarity;
  logic hostPinEnable;
  logic [2:0] chargeCurrentCode;
  logic [2:0] terminationCurrentCode;
  int miscompares = 0; // failed comparisons
  int nCompared = 0; // comparisons made
  int cycles = 0; // timeout counter
  logic [7:0] pat [4] = '{8'hC6, 8'h39, 8'hA5, 8'h5A}; // each bit both ways
  logic ok; // acknowledge of a raw transfer

  // wire is low if either party pulls
  assign sdaLine = !(sdaOe && !sdaOut) && !sdaPull;
  // field outputs regrouped as register bytes
  wire logic [7:0] ctrlPins = {inputCurrentLimitSel, weakBatteryThreshold,
    terminationEnable, chargeDisable, highImpedanceSelect, boostSelect};
  wire logic [7:0] fvPins = {floatVoltageCode, hostPinPolarity,
    hostPinEnable};
  wire logic [7:0] icPins = {1'b1, chargeCurrentCode, 1'b1,
    terminationCurrentCode};

  charger_control_registers #(.SUPPLIER_CODE(SUP), .VARIANT_CODE(VARI),
    .SILICON_VERSION(VERS), .SLAVE_ADDR(7'h6B)) dut (
    .core_clk(core_clk),
    .nrst(nrst),
    .scl(scl),
    .sdaIn(sdaLine),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .inputCurrentLimitSel(inputCurrentLimitSel),
    .weakBatteryThreshold(weakBatteryThreshold),
    .terminationEnable(terminationEnable),
    .chargeDisable(chargeDisable),
    .highImpedanceSelect(highImpedanceSelect),
    .boostSelect(boostSelect),
    .floatVoltageCode(floatVoltageCode),
    .hostPinPolarity(hostPinPolarity),
    .hostPinEnable(hostPinEnable),
    .chargeCurrentCode(chargeCurrentCode),
    .terminationCurrentCode(terminationCurrentCode)
  );

  host_master_model host (
    .core_clk(core_clk),
    .sdaLine(sdaLine),
    .scl(scl),
    .sdaPull(sdaPull)
  );

  // 5 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // run needs about 20k cycles; double that means a hang
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      finish_test();
    end
  end

  // byte comparison, four-state exact
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k;
    host.write_reg(a, d, k);
    chk({7'h00, k}, 8'h01);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic k;
    logic [7:0] q;
    host.read_reg(a, q, k);
    chk({7'h00, k}, 8'h01);
    chk(q, e);
  endtask : rd

  // one transfer each way over two registers; pointer steps by itself
  task automatic burst(input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] q;
    logic [7:0] r0;
    logic [7:0] r1;
    logic [3:0] k;
    host.start_cond();
    host.xfer({host.dev, 1'b0}, 1'b1, q, k[3]);
    host.xfer(8'h01, 1'b1, q, k[2]);
    host.xfer(d0, 1'b1, q, k[1]);
    host.xfer(d1, 1'b1, q, k[0]);
    host.stop_cond();
    chk({4'h0, k}, 8'h0F);
    chk(ctrlPins, d0);
    chk(fvPins, d1);
    host.start_cond();
    host.xfer({host.dev, 1'b0}, 1'b1, q, k[3]);
    host.xfer(8'h01, 1'b1, q, k[2]);
    host.start_cond();
    host.xfer({host.dev, 1'b1}, 1'b1, q, k[1]);
    host.xfer(8'hFF, 1'b0, r0, k[0]);
    host.xfer(8'hFF, 1'b1, r1, k[0]);
    host.stop_cond();
    chk({5'h00, k[3:1]}, 8'h07);
    chk(r0, d0);
    chk(r1, d1);
  endtask : burst

  task automatic finish_test();
    $display("compared %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  // main sequence
  initial
  begin
    nrst = 1'b0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(ctrlPins, 8'h30);
    chk(fvPins, 8'h0A);
    chk(icPins, 8'h89);
    rd(8'h01, 8'h30);
    rd(8'h02, 8'h0A);
    rd(8'h04, 8'h89);
    rd(8'h03, ID);
    rd(8'h3B, ID);
    $display("test reset values done");
    foreach (pat[i])
    begin
      host.phase = (i == 3) ? 9 : 4; // last pass as a slow host
      wr(8'h01, pat[i]);
      chk(ctrlPins, pat[i]);
      rd(8'h01, pat[i]);
      wr(8'h02, pat[i]);
      chk(fvPins, pat[i]);
      rd(8'h02, pat[i]);
      wr(8'h04, pat[i] & 8'h7F);
      chk(icPins, pat[i] | 8'h88);
      rd(8'h04, pat[i] | 8'h88);
    end
    host.phase = 4;
    $display("test field patterns done");
    burst(8'h9C, 8'h63);
    $display("test burst transfer done");
    wr(8'h03, ~ID);
    rd(8'h03, ID);
    wr(8'h3B, 8'h00);
    rd(8'h3B, ID);
    $display("test identity read-only done");
    wr(8'h04, 8'h80);
    chk(ctrlPins, 8'h30);
    rd(8'h01, 8'h30);
    rd(8'h02, 8'h0A);
    rd(8'h04, 8'h89);
    $display("test parameter reset done");
    host.dev = 7'h6A; // foreign slave address
    host.write_reg(8'h01, 8'h00, ok);
    chk({7'h00, ok}, 8'h00);
    host.dev = 7'h6B;
    rd(8'h01, 8'h30);
    rd(8'h05, 8'h00);
    $display("test addressing done");
    finish_test();
  end
endmodule : charger_control_registers_test

// ==== charger_map.svh ====
// register map, field positions and reset values of the charger bank
`ifndef CHARGER_MAP_SVH
`define CHARGER_MAP_SVH

// register offsets
`define CTRL_ADDR 8'h01
`define FVOLT_ADDR 8'h02
`define ID_ADDR 8'h03
`define ID_ALIAS_ADDR 8'h3B
`define ICUR_ADDR 8'h04

// reset values
`define CTRL_RST 8'h30
`define FVOLT_RST 8'h0A
`define ICUR_RST 8'h89

// charge control fields
`define ILIM_HI 7
`define ILIM_LO 6
`define WEAK_HI 5
`define WEAK_LO 4
`define TERM_BIT 3
`define CDIS_BIT 2
`define HIZ_BIT 1
`define BOOST_BIT 0

// float voltage fields
`define FV_HI 7
`define FV_LO 2
`define POL_BIT 1
`define HPEN_BIT 0

// charge current fields
`define PRST_BIT 7
`define ICHG_HI 6
`define ICHG_LO 4
`define TCUR_HI 2
`define TCUR_LO 0
`define ICUR_FIXED 8'h88

// serial bus
`define SLAVE_ADDR 7'h6B
`define LAST_BIT 3'h7

`endif

// ==== charger_pkg.sv ====
// types shared by the charger register bank
package charger_pkg;
  // serial engine states
  typedef enum logic [2:0] {IDLE, RX_BYTE, ACK_WAIT, ACK_HOLD, TX_BYTE,
    MASTER_ACK} link_state_e;
  // meaning of the byte being received
  typedef enum logic [1:0] {KIND_ADDR, KIND_REG, KIND_DATA} byte_kind_e;
endpackage : charger_pkg

// ==== charger_reg_store.sv ====
// writable charge parameter registers with parameter reset
`timescale 1ns/1ps
`include "charger_map.svh"
module charger_reg_store (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wrEn,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData,
  output logic [7:0] chargeControl,
  output logic [7:0] floatVoltageControl,
  output logic [7:0] chargeCurrentControl
);
  logic paramReset; // a one written to the reset bit

  assign paramReset = wrEn && wrAddr == `ICUR_ADDR
    && wrData[`PRST_BIT];

  // charge control, defaults on reset or parameter reset
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      chargeControl <= `CTRL_RST;
    else if (paramReset)
      chargeControl <= `CTRL_RST;
    else if (wrEn && wrAddr == `CTRL_ADDR)
      chargeControl <= wrData;
  end

  // float voltage code and host pin controls
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      floatVoltageControl <= `FVOLT_RST;
    else if (paramReset)
      floatVoltageControl <= `FVOLT_RST;
    else if (wrEn && wrAddr == `FVOLT_ADDR)
      floatVoltageControl <= wrData;
  end

  // charge current; top bit and spare bit always read one
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      chargeCurrentControl <= `ICUR_RST;
    else if (paramReset)
      chargeCurrentControl <= `ICUR_RST;
    else if (wrEn && wrAddr == `ICUR_ADDR)
      chargeCurrentControl <= wrData | `ICUR_FIXED;
  end
endmodule : charger_reg_store

// ==== host_master_model.sv ====
// two-wire bus master model standing in for the host processor
`timescale 1ns/1ps
module host_master_model (
  input wire logic core_clk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaPull
);
  int phase = 4; // core clocks per bus phase, raised for a slow host
  logic [6:0] dev = 7'h6B; // slave address put on the bus

  // idle bus: clock high, data left to the pull-up
  initial
  begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end

  // one bus phase; levels only move at rising edges
  task automatic tick();
    repeat (phase) @(posedge core_clk);
  endtask : tick

  // clock high for a phase, then low for a phase; sampled mid-cycle to stay clear of edge races
  task automatic pulse(output logic b);
    scl <= 1'b1;
    repeat (phase - 1) @(posedge core_clk);
    @(negedge core_clk) b = sdaLine;
    @(posedge core_clk);
    scl <= 1'b0;
    tick();
  endtask : pulse

  // data set a full phase after the fall, so hold time is generous
  task automatic put_bit(input logic b, output logic s);
    sdaPull <= !b;
    tick();
    pulse(s);
  endtask : put_bit

  // byte msb first, then the ninth bit; a 1 releases the line
  task automatic xfer(input logic [7:0] d, input logic ackOut,
      output logic [7:0] q, output logic ack9);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(d[i], s);
      q[i] = s;
    end
    put_bit(ackOut, s);
    ack9 = !s;
  endtask : xfer

  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    sdaPull <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sdaPull <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask : start_cond

  // stop: data rises while the clock is high, bus left idle
  task automatic stop_cond();
    sdaPull <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sdaPull <= 1'b0;
    tick();
  endtask : stop_cond

  // address, register pointer, one data byte
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
      output logic ok);
    logic [7:0] q;
    logic k1;
    logic k2;
    logic k3;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, q, k1);
    xfer(a, 1'b1, q, k2);
    xfer(d, 1'b1, q, k3);
    stop_cond();
    ok = k1 & k2 & k3;
  endtask : write_reg

  // pointer write, repeated start, one byte read and refused
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
      output logic ok);
    logic [7:0] q;
    logic k1;
    logic k2;
    logic k3;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, q, k1);
    xfer(a, 1'b1, q, k2);
    start_cond();
    xfer({dev, 1'b1}, 1'b1, q, k3);
    ok = k1 & k2 & k3;
    xfer(8'hFF, 1'b1, d, k1);
    stop_cond();
  endtask : read_reg
endmodule : host_master_model
